// ### src/fes_pkg.sv
// fes_pkg: command codes, status bit positions and timing for the flash sequencer host
`default_nettype none
package fes_pkg;
  // ***************************************************
  // command codes written on the data bus
  // ***************************************************
  localparam logic [7:0] CMD_CHIP_ERASE_SETUP = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_BUF_SETUP = 8'hE8;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'hD0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  // ***************************************************
  // status and extended status bit positions
  // ***************************************************
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_VPP_ERR = 3;
  localparam int SR_LOCK_ERR = 1;
  localparam int XSR_BUF_AVAIL = 7;
  // ***************************************************
  // buffer limits and bus timing
  // ***************************************************
  localparam logic [4:0] MAX_CNT_BYTE = 5'h1F;
  localparam logic [4:0] MAX_CNT_WORD = 5'h0F;
  localparam int WE_LOW_NS = 50;
  localparam int CLK_NS = 10;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // ***************************************************
  // operations and bus states
  // ***************************************************
  typedef enum logic [2:0] {
    FES_OP_CHIP_ERASE = 3'h0,
    FES_OP_PROGRAM = 3'h1,
    FES_OP_BUFFERED = 3'h2,
    FES_OP_SUSPEND = 3'h3,
    FES_OP_RESUME = 3'h4,
    FES_OP_CLEAR = 3'h5,
    FES_OP_READ = 3'h6
  } fes_op_t;
  typedef enum logic [1:0] {
    FES_BUS_IDLE = 2'b00,
    FES_BUS_LOW = 2'b01,
    FES_BUS_HIGH = 2'b11,
    FES_BUS_READ = 2'b10
  } fes_bus_t;
endpackage : fes_pkg
`default_nettype wire

// ### src/fes_bus_cycle.sv
// fes_bus_cycle: one flash bus write or read cycle with strobe timing
`default_nettype none
module fes_bus_cycle
  import fes_pkg::*;
#(
  parameter int AW = 21
) (
  // clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // request
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  // flash pins
  output logic [AW-1:0] addr_o,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe_n_o,
  output logic write_strobe_n_o,
  output logic output_enable_n_o
);
  fes_bus_t st_q;
  logic [3:0] cnt_q;
  wire logic cnt_done = (cnt_q == 4'(WE_LOW_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= FES_BUS_IDLE;
      cnt_q <= 4'h0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      addr_o <= '0;
      dq_o <= 16'h0000;
      dq_oe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
    end else if (en_i) begin
      done_o <= 1'b0;
      case (st_q)
        FES_BUS_IDLE: begin
          cnt_q <= 4'h0;
          if (req_i) begin
            addr_o <= addr_i;
            dq_o <= wdata_i;
            dq_oe_n_o <= !wr_i;
            write_strobe_n_o <= !wr_i;
            output_enable_n_o <= wr_i;
            st_q <= wr_i ? FES_BUS_LOW : FES_BUS_READ;
          end
        end
        FES_BUS_LOW: begin
          cnt_q <= cnt_q + 4'h1;
          // address and data latch on the rising strobe edge
          if (cnt_done) begin
            write_strobe_n_o <= 1'b1;
            st_q <= FES_BUS_HIGH;
          end
        end
        FES_BUS_HIGH: begin
          // hold data one cycle past the rising edge
          dq_oe_n_o <= 1'b1;
          done_o <= 1'b1;
          st_q <= FES_BUS_IDLE;
        end
        FES_BUS_READ: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_done) begin
            rdata_o <= dq_i;
            output_enable_n_o <= 1'b1;
            done_o <= 1'b1;
            st_q <= FES_BUS_IDLE;
          end
        end
        default: st_q <= FES_BUS_IDLE;
      endcase
    end
  end

  a_strobe_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && $fell(write_strobe_n_o) |-> !write_strobe_n_o[*4])
    else $error("write strobe low phase too short");
  a_data_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(write_strobe_n_o) |-> !dq_oe_n_o)
    else $error("data released before strobe rise");
endmodule : fes_bus_cycle
`default_nettype wire

// ### src/fes_host.sv
// fes_host: host controller sequencing erase, program and suspend commands on a NOR flash
//
// Functional notes
// - chip erase is setup then confirm D0; device walks blocks 0 to 31.
// - word program is setup 40 or 10, then address and data cycle.
// - buffered setup E8 with address; retry until buffer available reads one.
// - next write is count minus one, max 1F byte or 0F word.
// - data from start address within count, then confirm D0 starts copy.
// - during suspend only reads, programs elsewhere, status and resume valid; the host does not track suspend and accepts any command after it.
`default_nettype none
module fes_host
  import fes_pkg::*;
#(
  parameter int AW = 21,
  parameter int BUF_WORDS = 32
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // user command port
  input wire logic cmd_valid_i,
  input wire fes_op_t cmd_op_i,
  input wire logic [AW-1:0] cmd_addr_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic [4:0] cmd_count_i,
  input wire logic byte_mode_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] status_o,
  output logic [15:0] rdata_o,
  output logic error_o,
  // buffered data supply
  output logic buf_data_req_o,
  input wire logic [15:0] buf_data_i,
  // flash pins
  output logic [AW-1:0] flash_addr_o,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_n_o,
  output logic flash_write_strobe_n_o,
  output logic flash_output_enable_n_o,
  input wire logic status_output_pin_i
);
  // ***************************************************
  // sequencer states
  // ***************************************************
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CMD1 = 4'b0001,
    S_CMD2 = 4'b0011,
    S_XSR = 4'b0010,
    S_COUNT = 4'b0110,
    S_DATA = 4'b0111,
    S_CONF = 4'b0101,
    S_POLL = 4'b0100,
    S_DONE = 4'b1100
  } fes_st_t;

  fes_st_t st_q;
  fes_op_t op_q;
  logic [AW-1:0] addr_q;
  logic [15:0] data_q;
  logic [4:0] cnt_q;
  // one bit wider than the count so a full byte-mode buffer can finish
  logic [5:0] idx_q;
  logic bus_req_q;
  logic bus_wr_q;
  logic [AW-1:0] bus_addr_q;
  logic [15:0] bus_wdata_q;
  logic bus_done;
  logic [15:0] bus_rdata;
  logic bus_busy_q;

  function automatic logic err_any(input logic [7:0] s);
    err_any = s[SR_ERASE_ERR] | s[SR_WRITE_ERR] | s[SR_VPP_ERR] | s[SR_LOCK_ERR];
  endfunction

  wire logic [4:0] cnt_max = byte_mode_i ? MAX_CNT_BYTE : MAX_CNT_WORD;
  wire logic [4:0] cnt_clip = (cmd_count_i > cnt_max) ? cnt_max : cmd_count_i;
  wire logic [7:0] rd8 = bus_rdata[7:0];
  wire logic issue = bus_req_q && !bus_busy_q;
  wire logic start = cmd_valid_i && cmd_ready_o;
  wire logic is_buf = (op_q == FES_OP_BUFFERED);
  wire logic [5:0] n_words = {1'b0, cnt_q} + 6'h01;
  wire logic last_data = (idx_q == n_words);
  // resume, clear and suspend return to the sequencer's idle state after one status read, ready or not
  wire logic one_cycle_op = (op_q == FES_OP_RESUME) || (op_q == FES_OP_CLEAR) ||
    (op_q == FES_OP_SUSPEND);
  // decoded from the request itself: the bus engine takes the word one edge after start
  wire logic [7:0] first_cmd =
    (cmd_op_i == FES_OP_CHIP_ERASE) ? CMD_CHIP_ERASE_SETUP :
    (cmd_op_i == FES_OP_PROGRAM) ? CMD_PROG_SETUP :
    (cmd_op_i == FES_OP_BUFFERED) ? CMD_BUF_SETUP :
    (cmd_op_i == FES_OP_SUSPEND) ? CMD_ERASE_SUSPEND :
    (cmd_op_i == FES_OP_RESUME) ? CMD_ERASE_RESUME :
    (cmd_op_i == FES_OP_CLEAR) ? CMD_CLEAR_STATUS : CMD_READ_ARRAY;

  // ***************************************************
  // bus cycle engine
  // ***************************************************
  fes_bus_cycle #(.AW(AW)) u_bus (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .req_i(issue),
    .wr_i(bus_wr_q),
    .addr_i(bus_addr_q),
    .wdata_i(bus_wdata_q),
    .done_o(bus_done),
    .rdata_o(bus_rdata),
    .addr_o(flash_addr_o),
    .dq_i(flash_dq_i),
    .dq_o(flash_dq_o),
    .dq_oe_n_o(flash_dq_oe_n_o),
    .write_strobe_n_o(flash_write_strobe_n_o),
    .output_enable_n_o(flash_output_enable_n_o)
  );

  // ***************************************************
  // command sequencer
  // ***************************************************
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [15:0] d);
    bus_req_q <= 1'b1;
    bus_wr_q <= wr;
    bus_addr_q <= a;
    bus_wdata_q <= d;
  endtask

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= S_IDLE;
      op_q <= FES_OP_READ;
      addr_q <= '0;
      data_q <= 16'h0000;
      cnt_q <= 5'h00;
      idx_q <= 6'h00;
      bus_req_q <= 1'b0;
      bus_wr_q <= 1'b0;
      bus_addr_q <= '0;
      bus_wdata_q <= 16'h0000;
      bus_busy_q <= 1'b0;
      cmd_ready_o <= 1'b1;
      done_o <= 1'b0;
      status_o <= 8'h00;
      rdata_o <= 16'h0000;
      error_o <= 1'b0;
      buf_data_req_o <= 1'b0;
    end else if (en_i) begin
      done_o <= 1'b0;
      buf_data_req_o <= 1'b0;
      if (issue) begin
        bus_req_q <= 1'b0;
        bus_busy_q <= 1'b1;
      end
      if (bus_done) begin
        bus_busy_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          if (start) begin
            op_q <= cmd_op_i;
            addr_q <= cmd_addr_i;
            data_q <= cmd_data_i;
            cnt_q <= cnt_clip;
            idx_q <= 6'h00;
            cmd_ready_o <= 1'b0;
            st_q <= S_CMD1;
            bus(1'b1, cmd_addr_i, {8'h00, first_cmd});
          end
        end
        S_CMD1: begin
          if (bus_done) begin
            if (op_q == FES_OP_READ) begin
              bus(1'b0, addr_q, 16'h0000);
              st_q <= S_DONE;
            end else if (op_q == FES_OP_CHIP_ERASE) begin
              bus(1'b1, addr_q, {8'h00, CMD_CONFIRM});
              st_q <= S_CMD2;
            end else if (op_q == FES_OP_PROGRAM) begin
              bus(1'b1, addr_q, data_q);
              st_q <= S_CMD2;
            end else if (is_buf) begin
              bus(1'b0, addr_q, 16'h0000);
              st_q <= S_XSR;
            end else begin
              bus(1'b0, addr_q, 16'h0000);
              st_q <= one_cycle_op ? S_POLL : S_DONE;
            end
          end
        end
        S_CMD2: begin
          if (bus_done) begin
            bus(1'b0, addr_q, 16'h0000);
            st_q <= S_POLL;
          end
        end
        S_XSR: begin
          if (bus_done) begin
            // buffer unavailable: the setup was ignored, write it again
            if (rd8[XSR_BUF_AVAIL]) begin
              bus(1'b1, addr_q, {11'h000, cnt_q});
              st_q <= S_COUNT;
            end else begin
              bus(1'b1, addr_q, {8'h00, CMD_BUF_SETUP});
              st_q <= S_CMD1;
            end
          end
        end
        S_COUNT: begin
          if (bus_done) begin
            buf_data_req_o <= 1'b1;
            st_q <= S_DATA;
          end
        end
        S_DATA: begin
          // consecutive addresses from start keep within start plus count
          if (!bus_req_q && !bus_busy_q && !buf_data_req_o && idx_q < n_words) begin
            bus(1'b1, addr_q + AW'(idx_q), buf_data_i);
            idx_q <= idx_q + 6'h01;
          end
          if (bus_done) begin
            if (last_data) begin
              bus(1'b1, addr_q, {8'h00, CMD_CONFIRM});
              st_q <= S_CONF;
            end else begin
              buf_data_req_o <= 1'b1;
            end
          end
        end
        S_CONF: begin
          if (bus_done) begin
            bus(1'b0, addr_q, 16'h0000);
            st_q <= S_POLL;
          end
        end
        S_POLL: begin
          if (bus_done) begin
            status_o <= rd8;
            // ready, or a suspend, resume or clear command, ends the wait
            if (rd8[SR_READY] || one_cycle_op) begin
              error_o <= err_any(rd8);
              done_o <= 1'b1;
              cmd_ready_o <= 1'b1;
              st_q <= S_IDLE;
            end else begin
              bus(1'b0, addr_q, 16'h0000);
            end
          end
        end
        S_DONE: begin
          if (bus_done) begin
            rdata_o <= bus_rdata;
            done_o <= 1'b1;
            cmd_ready_o <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  a_count_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_q == S_COUNT |-> cnt_q <= MAX_CNT_BYTE)
    else $error("buffer count above limit");
  a_done_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_o |-> cmd_ready_o)
    else $error("done without ready");
  a_poll_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && st_q == S_POLL && bus_done && rd8[SR_READY] |=> done_o)
    else $error("ready status did not end the poll");
  a_conf_after: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && st_q == S_DATA && bus_done && last_data |=> st_q == S_CONF)
    else $error("confirm did not follow last data");
  a_xsr_retry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && st_q == S_XSR && bus_done && !rd8[XSR_BUF_AVAIL] |=> st_q == S_CMD1)
    else $error("setup not repeated");
  a_err_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(done_o) && st_q == S_IDLE && $past(st_q) == S_POLL |->
      error_o == err_any(status_o))
    else $error("error flag mismatch");
  c_chip_erase: cover property (@(posedge clk_i) done_o && op_q == FES_OP_CHIP_ERASE);
  c_buffered: cover property (@(posedge clk_i) done_o && op_q == FES_OP_BUFFERED);
  c_suspend: cover property (@(posedge clk_i) done_o && op_q == FES_OP_SUSPEND);
endmodule : fes_host
`default_nettype wire

// ### testbench/fes_flash_model.sv
// fes_flash_model: behavioural flash device answering the host's bus cycles
`default_nettype none
module fes_flash_model
  import fes_pkg::*;
#(
  parameter int AW = 21,
  parameter int BUSY_CYC = 40
) (
  // clock, reset and supply
  input wire logic clk_i,
  input wire logic reset_powerdown_n_i,
  input wire logic program_supply_high_i,
  input wire logic write_protect_n_i,
  input wire logic [31:0] lock_bits_i,
  // flash pins
  input wire logic [AW-1:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  input wire logic write_strobe_n_i,
  input wire logic output_enable_n_i,
  output logic status_output_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [2:0] {
    FM_ARRAY, FM_STATUS, FM_NOBUF, FM_PROG, FM_ERASE, FM_COUNT, FM_DATA, FM_CONF
  } fes_mode_t;
  fes_mode_t st_q = FM_ARRAY;
  logic [15:0] mem [int];
  logic [15:0] bdata [32];
  logic [AW-1:0] start_q;
  logic [7:0] sr_q = 8'h00;
  int cnt_q;
  int n_q;
  longint cyc = 0;
  longint busy_end = 0;
  wire logic busy = cyc < busy_end;
  wire logic avail = !(sr_q[4] | sr_q[5]);
  // ********
  // array helpers
  // ********
  function automatic logic [15:0] rd(input logic [AW-1:0] a);
    return mem.exists(a) ? mem[a] : ERASED_WORD;
  endfunction
  function automatic logic [7:0] guard(input logic [AW-1:0] a);
    if (!program_supply_high_i) return 8'h18;
    if (lock_bits_i[a[AW-1 -: 5]] && !write_protect_n_i) return 8'h12;
    return 8'h00;
  endfunction
  task automatic commit();
    logic [7:0] e;
    logic [AW-1:0] a;
    e = guard(start_q);
    for (int i = 0; i <= cnt_q; i++) begin
      a = start_q + AW'(i);
      if (a[AW-1 -: 5] != start_q[AW-1 -: 5]) e = e | 8'h30;
      if (e == 8'h00) mem[a] = rd(a) & bdata[i];
    end
    sr_q = sr_q | e;
    busy_end = cyc + BUSY_CYC;
  endtask
  task automatic erase_all();
    for (int b = 0; b < 32; b++) begin
      if (!lock_bits_i[b] || write_protect_n_i) begin
        foreach (mem[k]) begin
          if (k[AW-1 -: 5] == b) mem[k] = ERASED_WORD;
        end
      end
    end
  endtask
  always @(posedge clk_i) cyc <= cyc + 1;
  // writes are taken on the rising strobe edge, as the device latches them
  always @(posedge write_strobe_n_i or negedge reset_powerdown_n_i) begin
    if (!reset_powerdown_n_i) begin
      st_q = FM_ARRAY;
      sr_q = 8'h00;
      busy_end = 0;
    end else begin
      case (st_q)
        FM_PROG: begin
          sr_q = sr_q | guard(addr_i);
          if (guard(addr_i) == 8'h00) mem[addr_i] = rd(addr_i) & dq_i;
          busy_end = cyc + BUSY_CYC;
          st_q = FM_STATUS;
        end
        FM_ERASE: begin
          if (dq_i[7:0] != CMD_CONFIRM) sr_q = sr_q | 8'h30;
          else if (!program_supply_high_i) sr_q = sr_q | 8'h28;
          else erase_all();
          busy_end = cyc + BUSY_CYC;
          st_q = FM_STATUS;
        end
        FM_COUNT: begin
          start_q = addr_i;
          cnt_q = int'(dq_i[7:0]);
          n_q = 0;
          st_q = (dq_i[7:0] > 8'(MAX_CNT_WORD)) ? FM_STATUS : FM_DATA;
          if (st_q == FM_STATUS) sr_q = sr_q | 8'h30;
        end
        FM_DATA: begin
          if (addr_i < start_q || addr_i > start_q + AW'(cnt_q)) begin
            sr_q = sr_q | 8'h30;
            st_q = FM_STATUS;
          end else begin
            bdata[5'(addr_i - start_q)] = dq_i;
            n_q++;
            if (n_q > cnt_q) st_q = FM_CONF;
          end
        end
        FM_CONF: begin
          if (dq_i[7:0] == CMD_CONFIRM) commit();
          else sr_q = sr_q | 8'h30;
          st_q = FM_STATUS;
        end
        default: begin
          case (dq_i[7:0])
            CMD_PROG_SETUP, CMD_PROG_SETUP_ALT: st_q = FM_PROG;
            CMD_CHIP_ERASE_SETUP: st_q = FM_ERASE;
            CMD_BUF_SETUP: st_q = avail ? FM_COUNT : FM_NOBUF;
            CMD_CLEAR_STATUS: sr_q = sr_q & 8'hC5;
            CMD_READ_ARRAY: st_q = FM_ARRAY;
            // suspend finds no pausable erase: chip erase runs on
            default: st_q = FM_STATUS;
          endcase
        end
      endcase
    end
  end
  // released bus toggles each cycle so a stale value never looks valid
  assign dq_o = output_enable_n_i ? (16'h5AA5 ^ {16{cyc[0]}}) :
                (st_q == FM_ARRAY) ? rd(addr_i) :
                (st_q == FM_COUNT || st_q == FM_NOBUF) ? {8'h00, avail, 7'h00} :
                {8'h00, !busy, sr_q[6:0]};
  assign status_output_pin_o = !busy;
endmodule // fes_flash_model
`default_nettype wire

// ### testbench/tb_fes_host.sv
// tb_fes_host: self-checking bench for the host against the flash model
`default_nettype none
module tb_fes_host
  import fes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic byte_mode_i = 1'b0;
  fes_op_t cmd_op_i = FES_OP_READ;
  logic [20:0] cmd_addr_i = 21'h00_0000;
  logic [15:0] cmd_data_i = 16'h0000;
  logic [15:0] buf_data_i = 16'h0000;
  logic [15:0] bbase = 16'h0000;
  logic [4:0] cmd_count_i = 5'h00;
  logic vpp = 1'b1;
  logic wp_n = 1'b0;
  logic [31:0] locks = 32'h0000_0008;
  logic cmd_ready_o, done_o, error_o, buf_data_req_o, sts;
  logic [7:0] status_o;
  logic [15:0] rdata_o, flash_dq_i, flash_dq_o;
  logic [20:0] flash_addr_o;
  logic flash_dq_oe_n_o, flash_write_strobe_n_o, flash_output_enable_n_o;
  int mismatches = 0;
  int n_compared = 0;
  int bidx = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  fes_host dut (
    .clk_i, .rst_n_i, .en_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_data_i,
    .cmd_count_i, .byte_mode_i, .cmd_ready_o, .done_o, .status_o, .rdata_o, .error_o,
    .buf_data_req_o, .buf_data_i, .flash_addr_o, .flash_dq_i, .flash_dq_o,
    .flash_dq_oe_n_o, .flash_write_strobe_n_o, .flash_output_enable_n_o,
    .status_output_pin_i(sts)
  );
  fes_flash_model mdl (
    .clk_i, .reset_powerdown_n_i(rst_n_i), .program_supply_high_i(vpp),
    .write_protect_n_i(wp_n), .lock_bits_i(locks), .addr_i(flash_addr_o),
    .dq_i(flash_dq_o), .dq_o(flash_dq_i), .write_strobe_n_i(flash_write_strobe_n_o),
    .output_enable_n_i(flash_output_enable_n_o), .status_output_pin_o(sts)
  );
  // next buffered word follows each request
  always @(posedge clk_i) begin
    if (buf_data_req_o === 1'b1) begin
      buf_data_i <= bbase + 16'(bidx);
      bidx <= bidx + 1;
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ********
  // command port access
  // ********
  task automatic run(input fes_op_t op, input logic [20:0] a, input logic [15:0] d,
                     input logic [4:0] c);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    cmd_count_i <= c;
    bbase <= d;
    bidx = 0;
    cmd_valid_i <= 1'b1;
    do begin
      @(negedge clk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 200);
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    do begin
      @(negedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic op_st(input fes_op_t op, input logic [20:0] a, input logic [15:0] d,
                       input logic [4:0] c, input logic [7:0] st);
    run(op, a, d, c);
    check("status byte", status_o, st);
  endtask
  task automatic rd_chk(input logic [20:0] a, input logic [15:0] exp);
    run(FES_OP_READ, a, 16'h0000, 5'h00);
    check("array word", rdata_o, exp);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    check("strobe idle", flash_write_strobe_n_o, 1'b1);
    op_st(FES_OP_PROGRAM, 21'h02_0010, 16'h1234, 5'h00, 8'h80);
    check("error flag", error_o, 1'b0);
    rd_chk(21'h02_0010, 16'h1234);
    op_st(FES_OP_PROGRAM, 21'h02_0010, 16'hFF0F, 5'h00, 8'h80);
    rd_chk(21'h02_0010, 16'h1204);
    op_st(FES_OP_PROGRAM, 21'h03_0020, 16'h0000, 5'h00, 8'h92);
    check("error flag", error_o, 1'b1);
    rd_chk(21'h03_0020, 16'hFFFF);
    op_st(FES_OP_PROGRAM, 21'h02_0011, 16'h00FF, 5'h00, 8'h92);
    run(FES_OP_CLEAR, 21'h00_0000, 16'h0000, 5'h00);
    vpp <= 1'b0;
    op_st(FES_OP_PROGRAM, 21'h02_0012, 16'h0000, 5'h00, 8'h98);
    run(FES_OP_CLEAR, 21'h00_0000, 16'h0000, 5'h00);
    vpp <= 1'b1;
    wp_n <= 1'b1;
    op_st(FES_OP_PROGRAM, 21'h03_0020, 16'h5555, 5'h00, 8'h80);
    wp_n <= 1'b0;
    op_st(FES_OP_CHIP_ERASE, 21'h00_0000, 16'h0000, 5'h00, 8'h80);
    rd_chk(21'h02_0010, 16'hFFFF);
    rd_chk(21'h03_0020, 16'h5555);
    vpp <= 1'b0;
    op_st(FES_OP_CHIP_ERASE, 21'h00_0000, 16'h0000, 5'h00, 8'hA8);
    rd_chk(21'h03_0020, 16'h5555);
    run(FES_OP_CLEAR, 21'h00_0000, 16'h0000, 5'h00);
    vpp <= 1'b1;
    wp_n <= 1'b1;
    op_st(FES_OP_CHIP_ERASE, 21'h00_0000, 16'h0000, 5'h00, 8'h80);
    rd_chk(21'h03_0020, 16'hFFFF);
    op_st(FES_OP_BUFFERED, 21'h04_0100, 16'hA500, 5'h03, 8'h80);
    for (int i = 0; i < 5; i++) begin
      rd_chk(21'h04_0100 + 21'(i), (i < 4) ? 16'hA500 + 16'(i) : 16'hFFFF);
    end
    op_st(FES_OP_BUFFERED, 21'h06_0000, 16'hC600, 5'h1F, 8'h80);
    rd_chk(21'h06_000F, 16'hC60F);
    rd_chk(21'h06_0010, 16'hFFFF);
    op_st(FES_OP_BUFFERED, 21'h05_FFFE, 16'hD700, 5'h03, 8'hB0);
    check("error flag", error_o, 1'b1);
    rd_chk(21'h05_FFFF, 16'hD701);
    rd_chk(21'h06_0000, 16'hC600);
    run(FES_OP_CLEAR, 21'h00_0000, 16'h0000, 5'h00);
    vpp <= 1'b0;
    op_st(FES_OP_BUFFERED, 21'h04_0200, 16'hE800, 5'h01, 8'h98);
    rd_chk(21'h04_0200, 16'hFFFF);
    run(FES_OP_CLEAR, 21'h00_0000, 16'h0000, 5'h00);
    vpp <= 1'b1;
    op_st(FES_OP_SUSPEND, 21'h00_0000, 16'h0000, 5'h00, 8'h80);
    op_st(FES_OP_PROGRAM, 21'h02_0010, 16'h0F0F, 5'h00, 8'h80);
    report_and_stop();
  end
endmodule // tb_fes_host
`default_nettype wire
